// [kms_consts.vh]
// constants for the keypad matrix scan encoder
// assumes a 50 MHz system clock and a 32-bit classic wishbone slave port
`ifndef KMS_CONSTS_VH
`define KMS_CONSTS_VH

// matrix shape
`define KMS_NUM_COLS      8
`define KMS_NUM_ROWS      10
`define KMS_NUM_KEYS      80
`define KMS_LAST_COL      3'h7
`define KMS_LAST_ROW      4'h9
`define KMS_ROWS_PER_COL  7'h0A
// columns that carry rotary switch contacts (forced off during init)
`define KMS_ROTARY_COLS   8'hE3

// instrument bus addresses and bit positions
`define KMS_ADDR_OUT      8'hF4
`define KMS_ADDR_IN       8'h74
`define KMS_INIT_BIT      3
`define KMS_POLL_BIT      0
`define KMS_MSB_BIT       7

// timing
`define KMS_CLK_MHZ       50
`define KMS_MASK_TIME_US  5000
`define KMS_INIT_HOLD_US  1000

// wishbone register offsets (byte addresses)
`define KMS_REG_CTRL      4'h0
`define KMS_REG_STATUS    4'h4
`define KMS_REG_DIV       4'h8
// field positions
`define KMS_CTRL_RUN      0
`define KMS_ST_STROBE     8
`define KMS_ST_MASK       9
`define KMS_ST_INIT       10
// reset values
`define KMS_CTRL_RESET    1'h1
`define KMS_DIV_RESET     16'h0032

`endif

// [kms_scan_encoder.v]
// keypad matrix scan encoder with instrument bus poll interface
// assumes row pins, freq direction and instrument bus come from outside the
// clock domain; an external buffer resolves bus levels from the enables
//
// Notes on behaviour
// - drive eight columns in turn, sense ten rows
// - row counter per tick, column steps after rows
// - one stored bit per key; new closure only
// - new closure starts mask, code latch and strobe together
// - mask suspends further change detection
// - latch loads code chosen by column and row
// - code is ten times column plus row
// - strobe high asserts active-low service request
// - strobe high releases preset on strobe control
// - strobe holds until strobe control rises
// - pending request drives poll bit low in poll
// - written-back low bit on poll end cancels request
// - row closed only through the active column
// - every rotary detent has its own position
// - init forces rotary columns off, stores zeros
// - after init rotary positions report as closures
// - output path enabled only at read address
// - read gives code low, knob direction high
`timescale 1ns/1ps
`include "kms_consts.vh"

module kms_scan_encoder #(
    parameter MASK_TIME_US  = `KMS_MASK_TIME_US, // debounce mask time
    parameter INIT_HOLD_US  = `KMS_INIT_HOLD_US  // init bit hold after write
) (
    input  wire        sys_clk,           // system clock, 50 MHz
    input  wire        rst_n,             // synchronous reset, active low
    // wishbone slave
    input  wire        wb_cyc_i,          // bus cycle
    input  wire        wb_stb_i,          // strobe
    input  wire        wb_we_i,           // write enable
    input  wire [3:0]  wb_adr_i,          // byte address
    input  wire [3:0]  wb_sel_i,          // byte lanes
    input  wire [31:0] wb_dat_i,          // write data
    output reg  [31:0] wb_dat_o,          // read data
    output reg         wb_ack_o,          // acknowledge
    // switch matrix
    output reg  [7:0]  column_drive,      // column drives, active high
    input  wire [9:0]  row_sense,         // row senses, high = closed
    input  wire        freq_dir,          // frequency knob direction
    // instrument bus
    input  wire [7:0]  ib_addr,           // address bus, bit 7 address_msb
    input  wire [7:0]  ib_data_in,        // data bus level seen
    output reg  [7:0]  ib_data_out,       // data bus drive value
    output reg  [7:0]  ib_data_oe,        // per-bit drive enable
    input  wire        ib_data_valid,     // data valid, active high
    input  wire        ib_poll,           // poll, active high
    output reg         service_request_n  // service request, active low
);

    // products kept at full width, then cut to the timer width on purpose
    localparam integer MASK_CYC_I  = MASK_TIME_US * `KMS_CLK_MHZ;
    localparam integer INIT_CYC_I  = INIT_HOLD_US * `KMS_CLK_MHZ;
    localparam [19:0]  MASK_CYCLES = MASK_CYC_I[19:0];
    localparam [19:0]  INIT_CYCLES = INIT_CYC_I[19:0];

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    ////////////////////////////////////////////////////////////////////////
    reg  [9:0]  row_s1_q;        // first stage
    reg  [9:0]  row_q;           // usable row levels
    reg  [19:0] ib_s1_q;         // first stage of bus inputs
    reg  [19:0] ib_q;            // usable bus inputs
    reg         dir_s1_q;        // first stage, knob direction
    reg         dir_q;           // usable knob direction
    wire [7:0]  ib_addr_s;       // synced address
    wire [7:0]  ib_data_s;       // synced data
    wire        ib_valid_s;      // synced data valid
    wire        ib_poll_s;       // synced poll

    assign ib_addr_s  = ib_q[7:0];
    assign ib_data_s  = ib_q[15:8];
    assign ib_valid_s = ib_q[16];
    assign ib_poll_s  = ib_q[17];

    // two flops each; nothing but the second stage reads the first
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            row_s1_q <= 10'h000;
            row_q    <= 10'h000;
            ib_s1_q  <= 20'h00000;
            ib_q     <= 20'h00000;
            dir_s1_q <= 1'h0;
            dir_q    <= 1'h0;
        end else begin
            row_s1_q <= row_sense;
            row_q    <= row_s1_q;
            ib_s1_q  <= {2'h0, ib_poll, ib_data_valid, ib_data_in, ib_addr};
            ib_q     <= ib_s1_q;
            dir_s1_q <= freq_dir;
            dir_q    <= dir_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wishbone registers
    ////////////////////////////////////////////////////////////////////////
    reg         run_q;           // scan enable
    reg  [15:0] div_q;           // system clocks per scan tick
    wire        wb_req;          // request awaiting answer
    wire        wb_wr;           // write takes effect now

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr  = wb_req & wb_we_i;

    // ack one cycle after the request; unmapped reads return zero
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'h0;
            run_q    <= `KMS_CTRL_RESET;
            div_q    <= `KMS_DIV_RESET;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_wr && wb_adr_i == `KMS_REG_CTRL && wb_sel_i[0]) begin
                run_q <= wb_dat_i[`KMS_CTRL_RUN];
            end
            if (wb_wr && wb_adr_i == `KMS_REG_DIV) begin
                if (wb_sel_i[0]) begin
                    div_q[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    div_q[15:8] <= wb_dat_i[15:8];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // scan tick and counters
    ////////////////////////////////////////////////////////////////////////
    reg  [15:0] tick_cnt_q;      // divider count
    reg         tick_q;          // one-cycle scan clock pulse
    reg  [3:0]  row_cnt_q;       // current row
    reg  [2:0]  col_cnt_q;       // current column
    reg         init_q;          // rotary init in force
    reg  [19:0] init_cnt_q;      // init hold timer

    // free-running timer; a divider of zero is read as one
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            tick_cnt_q <= 16'h0000;
            tick_q     <= 1'h0;
        end else if (run_q && tick_cnt_q + 16'h0001 >= div_q) begin
            tick_cnt_q <= 16'h0000;
            tick_q     <= 1'h1;
        end else begin
            tick_cnt_q <= run_q ? tick_cnt_q + 16'h0001 : 16'h0000;
            tick_q     <= 1'h0;
        end
    end

    // rows step per tick, columns step after the last row
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            row_cnt_q <= 4'h0;
            col_cnt_q <= 3'h0;
        end else if (tick_q) begin
            if (row_cnt_q == `KMS_LAST_ROW) begin
                row_cnt_q <= 4'h0;
                col_cnt_q <= (col_cnt_q == `KMS_LAST_COL) ? 3'h0
                                                           : col_cnt_q + 3'h1;
            end else begin
                row_cnt_q <= row_cnt_q + 4'h1;
            end
        end
    end

    // one column driven at a time; rotary columns held off during init
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            column_drive <= 8'h00;
        end else begin
            column_drive <= (8'h01 << col_cnt_q)
                            & ~(init_q ? `KMS_ROTARY_COLS : 8'h00);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // init bit: not latched by the host, so held by a retriggered timer
    ////////////////////////////////////////////////////////////////////////
    wire        ib_write_in;     // write to the input port
    assign ib_write_in = ib_valid_s & ~ib_poll_s & (ib_addr_s == `KMS_ADDR_IN);

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            init_q     <= 1'h0;
            init_cnt_q <= 20'h00000;
        end else if (ib_write_in && ib_data_s[`KMS_INIT_BIT]) begin
            init_q     <= 1'h1;
            init_cnt_q <= INIT_CYCLES;
        end else if (ib_write_in || init_cnt_q == 20'h00000) begin
            init_q     <= 1'h0;
            init_cnt_q <= 20'h00000;
        end else begin
            init_cnt_q <= init_cnt_q - 20'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // key memory, compare, debounce and code latch
    ////////////////////////////////////////////////////////////////////////
    reg  [`KMS_NUM_KEYS-1:0] key_q;  // state seen on last scan
    reg  [6:0]  code_q;          // character register
    reg  [19:0] mask_cnt_q;      // debounce mask timer
    reg         strobe_q;        // encoder strobe
    wire [6:0]  key_idx;         // position index
    wire        col_rotary;      // current column is rotary
    wire        sample;          // row level for current key
    wire        mask_on;         // mask active
    wire        change;          // stored bit differs
    wire        event_new;       // new closure
    wire        strobe_clr;      // strobe control rising

    // each detent is its own position; code equals the position index
    assign key_idx    = {4'h0, col_cnt_q} * `KMS_ROWS_PER_COL
                        + {3'h0, row_cnt_q};
    assign col_rotary = |((8'h01 << col_cnt_q) & `KMS_ROTARY_COLS);
    // a row only reads closed through the driven column
    assign sample     = row_q[row_cnt_q] & column_drive[col_cnt_q]
                        & ~(init_q & col_rotary);
    assign mask_on    = (mask_cnt_q != 20'h00000);
    assign change     = tick_q & ~mask_on & (sample != key_q[key_idx]);
    assign event_new  = change & sample;

    // stored bits follow the matrix; only closures raise an event
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            key_q <= {`KMS_NUM_KEYS{1'b0}};
        end else if (change) begin
            key_q[key_idx] <= sample;
        end
    end

    // a new closure starts mask, latch and strobe in the same cycle
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            mask_cnt_q <= 20'h00000;
            code_q     <= 7'h00;
        end else if (event_new) begin
            mask_cnt_q <= MASK_CYCLES;
            code_q     <= key_idx;
        end else if (mask_on) begin
            mask_cnt_q <= mask_cnt_q - 20'h00001;
        end
    end

    // a new closure wins over a cancel in the same cycle
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            strobe_q <= 1'h0;
        end else if (event_new) begin
            strobe_q <= 1'h1;
        end else if (strobe_clr) begin
            strobe_q <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt interface: strobe control flop and poll handling
    ////////////////////////////////////////////////////////////////////////
    reg         ctl_q;           // strobe control input level
    reg         ctl_d1_q;        // previous level for edge
    reg         poll_d1_q;       // previous poll level
    reg         wb_bit_q;        // written-back poll bit
    wire        poll_end;        // poll removed

    assign poll_end   = poll_d1_q & ~ib_poll_s;
    assign strobe_clr = ctl_q & ~ctl_d1_q;

    // preset holds control low until strobe rises; low bit on poll end
    // produces the rising edge that cancels the request
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            ctl_q     <= 1'h0;
            ctl_d1_q  <= 1'h0;
            poll_d1_q <= 1'h0;
            wb_bit_q  <= 1'h1;
        end else begin
            ctl_d1_q  <= ctl_q;
            poll_d1_q <= ib_poll_s;
            // write-back phase: address msb low while poll is up
            if (ib_poll_s && ib_valid_s && !ib_addr_s[`KMS_MSB_BIT]) begin
                wb_bit_q <= ib_data_s[`KMS_POLL_BIT];
            end else if (poll_end) begin
                wb_bit_q <= 1'h1;
            end
            if (!strobe_q) begin
                ctl_q <= 1'h0;
            end else if (poll_end && !wb_bit_q) begin
                ctl_q <= 1'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // instrument bus drivers and wishbone read data
    ////////////////////////////////////////////////////////////////////////
    wire        poll_drive;      // poll bit pulled low
    wire        read_out;        // output path addressed
    wire [31:0] status_word;     // status register view

    // host disables the poll driver by dropping address msb
    assign poll_drive = ib_poll_s & ib_addr_s[`KMS_MSB_BIT]
                        & strobe_q;
    assign read_out   = ib_valid_s & ~ib_poll_s
                        & (ib_addr_s == `KMS_ADDR_OUT);
    assign status_word = {21'h000000, init_q, mask_on, strobe_q, 1'h0,
                          code_q};

    // buffered drive, one cycle behind the synced bus
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            ib_data_out       <= 8'h00;
            ib_data_oe        <= 8'h00;
            service_request_n <= 1'h1;
        end else begin
            service_request_n <= ~strobe_q;
            if (read_out) begin
                ib_data_out <= {dir_q, code_q};
                ib_data_oe  <= 8'hFF;
            end else if (poll_drive) begin
                ib_data_out <= 8'h00;
                ib_data_oe  <= 8'h01 << `KMS_POLL_BIT;
            end else begin
                ib_data_out <= 8'h00;
                ib_data_oe  <= 8'h00;
            end
        end
    end

    // read data registered with ack
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h00000000;
        end else if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                `KMS_REG_CTRL:   wb_dat_o <= {31'h00000000, run_q};
                `KMS_REG_STATUS: wb_dat_o <= status_word;
                `KMS_REG_DIV:    wb_dat_o <= {16'h0000, div_q};
                default:         wb_dat_o <= 32'h00000000;
            endcase
        end
    end

endmodule

// [kms_scan_encoder_props.sv]
// port checker for the keypad matrix scan encoder
// assumes a bind onto every instance of the encoder
`timescale 1ns/1ps
module kms_scan_props (
    input wire       sys_clk,          // clock
    input wire       rst_n,            // reset, active low
    input wire       wb_cyc_i,         // bus cycle
    input wire       wb_stb_i,         // strobe
    input wire       wb_ack_o,         // acknowledge
    input wire [7:0] column_drive,     // column drives
    input wire [7:0] ib_addr,          // instrument address
    input wire [7:0] ib_data_out,      // data drive value
    input wire [7:0] ib_data_oe,       // data drive enable
    input wire       ib_data_valid,    // data valid
    input wire       ib_poll,          // poll
    input wire       service_request_n // request, active low
);
    reg [3:0] poll_gap_q; // cycles since poll was high
    reg [3:0] bus_gap_q;  // cycles since valid or poll was high
    ////////////////////////////////////////////////////////////////////
    // saturating gaps give the request and data drive checks a bounded cause window
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            poll_gap_q <= 4'hF;
            bus_gap_q  <= 4'hF;
        end else begin
            poll_gap_q <= ib_poll ? 4'h0
                        : poll_gap_q + {3'h0, poll_gap_q != 4'hF};
            bus_gap_q  <= (ib_poll | ib_data_valid) ? 4'h0
                        : bus_gap_q + {3'h0, bus_gap_q != 4'hF};
        end
    end
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    col_onehot_a: assert property ($onehot0(column_drive))
        else $error("column drive not one-hot");
    col_order_a: assert property (
        $changed(column_drive) && column_drive != 0 && $past(column_drive) != 0
        |-> column_drive == {$past(column_drive[6:0]), $past(column_drive[7])})
        else $error("column order broken");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    srq_hold_a: assert property (
        $rose(service_request_n) |-> poll_gap_q <= 4'hA)
        else $error("request dropped without poll end");
    poll_drive_a: assert property (
        (!service_request_n && ib_poll && ib_addr[7]) [*5]
        |-> ib_data_oe[0] && !ib_data_out[0])
        else $error("poll bit not driven low");
    bus_gate_a: assert property (
        ib_data_oe != 8'h00 |-> bus_gap_q <= 4'h6)
        else $error("data driven with no bus access");
    f4_drive_a: assert property (
        (ib_data_valid && !ib_poll && ib_addr == 8'hF4) [*5]
        |-> ib_data_oe == 8'hFF)
        else $error("output path not driven");
    // main scenarios
    c_request: cover property ($fell(service_request_n));
    c_poll: cover property (ib_data_oe == 8'h01);
    c_read: cover property (ib_data_oe == 8'hFF);
endmodule
bind kms_scan_encoder kms_scan_props props_i (.sys_clk, .rst_n, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .column_drive, .ib_addr, .ib_data_out, .ib_data_oe,
    .ib_data_valid, .ib_poll, .service_request_n);

// [kms_host_model.sv]
// host side of the instrument bus: reads, writes and the parallel poll
// assumes the bench resolves data wires from both enables, with pull-ups
`timescale 1ns/1ps
module kms_host_model (
    input  wire       sys_clk,       // clock
    output reg  [7:0] ib_addr,       // address, bit 7 address_msb
    output reg  [7:0] host_data,     // data drive value
    output reg        host_oe,       // data drive enable
    output reg        ib_data_valid, // data valid
    output reg        ib_poll,       // poll
    input  wire [7:0] ib_data_in     // resolved data wires
);
    // idle: invalid address, nothing driven
    initial begin
        ib_addr = 8'hFF;
        host_data = 8'h00;
        host_oe = 1'b0;
        ib_data_valid = 1'b0;
        ib_poll = 1'b0;
    end
    // each phase outlasts the port synchronisers
    task automatic gap;
        repeat (6) @(posedge sys_clk);
    endtask
    // write cycle; the init bit is rewritten by the caller, not latched
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        ib_addr <= a;
        host_data <= d;
        host_oe <= 1'b1;
        ib_data_valid <= 1'b1;
        gap();
        ib_data_valid <= 1'b0;
        gap();
        host_oe <= 1'b0;
        ib_addr <= 8'hFF;
        @(posedge sys_clk);
    endtask
    // read cycle, data taken at the last held edge
    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        ib_addr <= a;
        ib_data_valid <= 1'b1;
        gap();
        d = ib_data_in;
        ib_data_valid <= 1'b0;
        ib_addr <= 8'hFF;
        @(posedge sys_clk);
    endtask
    // poll: read the byte, drop address msb, write it back, end poll
    task automatic poll_cycle(output logic [7:0] b);
        ib_poll <= 1'b1;
        ib_data_valid <= 1'b1;
        gap();
        b = ib_data_in;
        ib_data_valid <= 1'b0;
        ib_addr <= 8'h7F;
        gap();
        host_data <= b;
        host_oe <= 1'b1;
        ib_data_valid <= 1'b1;
        gap();
        ib_data_valid <= 1'b0;
        gap();
        ib_poll <= 1'b0;
        gap();
        host_oe <= 1'b0;
        ib_addr <= 8'hFF;
        @(posedge sys_clk);
    endtask
endmodule

// [keypad_matrix_scan_encoder_tb_top.sv]
// self-checking bench for the keypad matrix scan encoder
// assumes the host model and pull-ups on the instrument data wires
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module keypad_matrix_scan_encoder_tb_top;
    reg         sys_clk = 1'b0, rst_n = 1'b0;       // clock, reset
    reg         wb_cyc_i = 1'b0, wb_stb_i = 1'b0;   // bus request
    reg         wb_we_i = 1'b0, freq_dir = 1'b0;    // direction, knob
    reg  [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF;   // address, lanes
    reg  [31:0] wb_dat_i = 32'h0;                   // write data
    wire [31:0] wb_dat_o;                           // read data
    wire        wb_ack_o, service_request_n;        // ack, request
    wire [7:0]  column_drive, ib_addr, ib_data_out, ib_data_oe, host_data;
    wire        host_oe, ib_data_valid, ib_poll;    // host controls
    reg  [9:0]  row_sense;                          // matrix rows
    reg  [79:0] keys_q = 80'h0;                     // closed contacts
    reg  [15:0] lfsr = 16'h9B59;                    // random state
    logic [31:0] exp_q[$], exp_v;                   // read notes
    logic [7:0] b;                                  // host byte
    integer     failures = 0, checked = 0, cycles = 0, n;
    // pull-ups win wherever nobody drives
    wire [7:0] bus = (ib_data_oe & ib_data_out)
                   | (~ib_data_oe & (host_oe ? host_data : 8'hFF));
    kms_scan_encoder #(.MASK_TIME_US(2), .INIT_HOLD_US(1)) uut (.sys_clk,
        .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .column_drive, .row_sense, .freq_dir,
        .ib_addr, .ib_data_in(bus), .ib_data_out, .ib_data_oe, .ib_data_valid,
        .ib_poll, .service_request_n);
    kms_host_model host (.sys_clk, .ib_addr, .host_data, .host_oe,
        .ib_data_valid, .ib_poll, .ib_data_in(bus));
    initial forever #10 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////
    // a row reads closed only through the driven column
    always @* begin
        row_sense = 10'h000;
        for (int c = 0; c < 8; c++)
            if (column_drive[c])
                row_sense |= keys_q[c*10 +: 10];
    end
    // read answers are checked against the oldest note
    always @(posedge sys_clk)
        if (wb_ack_o === 1'b1 && !wb_we_i) begin
            exp_v = exp_q.pop_front();
            `CHK(wb_dat_o, exp_v)
        end
    // a hang ends the run as a failure
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            finish_test;
        end
    end
    ////////////////////////////////////////////////////////////////////
    function automatic [15:0] lfsr_next(input [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic finish_test;
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // classic single cycle, held until ack is sampled
    task automatic wb(input bit we, input logic [3:0] a, input logic [31:0] d);
        if (!we)
            exp_q.push_back(d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= we ? d : 32'h0;
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wait_srq(input logic v);
        for (int i = 0; i < 3000 && service_request_n !== v; i++)
            @(posedge sys_clk);
    endtask
    // press a key, follow its request to the cancel, maybe let go
    task automatic key(input int idx, input bit rel);
        keys_q[idx] <= 1'b1;
        freq_dir <= lfsr[0];
        wait_srq(1'b0);
        wb(0, 4'h4, 32'h300 + idx);
        repeat (150) @(posedge sys_clk);
        `CHK(service_request_n, 1'b0)
        wb(0, 4'h4, 32'h100 + idx);
        host.bus_rd(8'hF4, b);
        `CHK(b, {freq_dir, idx[6:0]})
        host.poll_cycle(b);
        `CHK(b[0], 1'b0)
        repeat (12) @(posedge sys_clk);
        `CHK(service_request_n, 1'b1)
        if (rel)
            keys_q[idx] <= 1'b0;
        repeat (400) @(posedge sys_clk);
        `CHK(service_request_n, 1'b1)
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge sys_clk);
        `CHK(column_drive, 8'h00)
        `CHK(service_request_n, 1'b1)
        rst_n <= 1'b1;
        @(posedge sys_clk);
        wb(0, 4'h0, 32'h1);
        wb(1, 4'h0, 32'h0);
        wb(0, 4'h0, 32'h0);
        wb(1, 4'h0, 32'h1);
        wb(0, 4'h8, 32'h32);
        wb(1, 4'hC, 32'hFFFF_FFFF);
        wb(0, 4'hC, 32'h0);
        wb(1, 4'h8, 32'h4);
        wb(0, 4'h8, 32'h4);
        // column walk: one-hot, ten ticks of four clocks each, wrapping
        while (column_drive !== 8'h02) @(posedge sys_clk);
        while (column_drive !== 8'h01) @(posedge sys_clk);
        for (int i = 1; i <= 8; i++) begin
            n = 0;
            do begin
                @(posedge sys_clk);
                n++;
            end while (column_drive === (8'h01 << ((i - 1) % 8)) && n < 99);
            `CHK(n, 40)
            `CHK(column_drive, 8'h01 << (i % 8))
        end
        key(0, 1);
        key(10, 1);
        key(79, 1);
        for (int j = 0; j < 2; j++) begin
            lfsr = lfsr_next(lfsr);
            key(lfsr % 80, 1);
        end
        // rotary detent held through init, then reported again
        key(1, 0);
        repeat (30) begin
            host.bus_wr(8'h74, 8'h08);
            `CHK(column_drive & 8'hE3, 8'h00)
        end
        `CHK(service_request_n, 1'b1)
        host.bus_wr(8'h74, 8'h00);
        wait_srq(1'b0);
        `CHK(service_request_n, 1'b0)
        // host records the detent it finds as the control's start position
        host.bus_rd(8'hF4, b);
        `CHK(b, {freq_dir, 7'h01})
        repeat (150) @(posedge sys_clk);
        wb(0, 4'h4, 32'h101);
        host.poll_cycle(b);
        `CHK(b[0], 1'b0)
        repeat (12) @(posedge sys_clk);
        `CHK(service_request_n, 1'b1)
        finish_test;
    end
endmodule
